/* File: hdl/fuse_config_and_signature.sv */
// Functional notes
// - Override fuse unprogrammed: PWM outputs act as ordinary port pins.
// - Override fuse programmed: PWM outputs forced at reset to fuse levels.
// - Forced levels hold until first write of PWM output config register.
// - Side A outputs high if its level fuse is 0, else low.
// - Side B outputs high if its level fuse is 0, else low.
// - Fuse bits read 0 when programmed, 1 when unprogrammed.
// - High byte layout: reset disable, debug, serial, watchdog, EE, boot, vector.
// - Serial programming enable fuse cannot be changed over the serial path.
// - Delivered high byte: serial enable and boot size programmed, rest not.
// - Low byte layout: div8, clock out, start-up 5:4, source 3:0.
// - Delivered low byte: div8 programmed, 8 MHz RC, longest start-up.
// - Clock output fuse programmed routes system clock to port B bit 0.
// - Chip erase leaves every fuse bit unchanged.
// - Fuse changes refused while the first memory lock bit is programmed.
// - Fuses captured on programming entry; changes apply after leaving.
// - EEPROM preserve fuse takes effect as soon as programmed.
// - Fuses also captured at power-up in normal mode.
// - Three identification bytes at addresses 0 to 2, separate space.
// - Identification readable on both paths, even when locked.
// - Calibration byte stored in upper byte of identification address 0.
// - Every reset copies the calibration byte into the trim register.
`timescale 1ns/1ps
`include "fuse_consts.svh"

module fuse_config_and_signature
    import fuse_pkg::*;
#(
    parameter logic [7:0] ID_BYTE0 = 8'h5a, // Arbitrary identification value
    parameter logic [7:0] ID_BYTE1 = 8'h3c, // Arbitrary identification value
    parameter logic [7:0] ID_BYTE2 = 8'ha5, // Arbitrary identification value
    parameter logic [7:0] CAL_VALUE = 8'h80,
    parameter int PWM_CHANNELS = 3
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic dev_reset_in,
    input wire logic prog_mode_in,
    input wire logic prog_serial_in,
    input wire logic fuse_wr_in,
    input wire logic [1:0] fuse_sel_in,
    input wire logic [7:0] wdata_in,
    input wire logic lock_wr_in,
    input wire logic chip_erase_in,
    input wire logic rd_in,
    input wire logic [1:0] rd_space_in,
    input wire logic [1:0] rd_addr_in,
    input wire logic poc_wr_in,
    input wire logic [PWM_CHANNELS-1:0] port_a_in,
    input wire logic [PWM_CHANNELS-1:0] port_b_in,
    input wire logic trim_wr_in,
    input wire logic [7:0] trim_wdata_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic wr_refused_out,
    output logic [PWM_CHANNELS-1:0] pwm_out_side_a_out,
    output logic [PWM_CHANNELS-1:0] pwm_out_side_b_out,
    output logic override_active_out,
    output logic [7:0] rc_osc_trim_out,
    output logic [7:0] fuse_low_out,
    output logic [7:0] fuse_high_out,
    output logic [7:0] fuse_ext_out,
    output logic eeprom_preserve_out,
    output logic portb0_clock_sel_out
);

    initial begin
        if (PWM_CHANNELS != 3) begin
            $error("PWM_CHANNELS: the override covers three per side");
        end
    end

    // Stored (non-volatile) bytes
    logic [7:0] nv_low;
    logic [7:0] nv_high;
    logic [7:0] nv_ext;
    logic [7:0] nv_lock;

    // Write decode
    logic fuse_unlocked;
    logic fuse_wr_ok;
    logic wr_low;
    logic wr_high;
    logic wr_ext;
    logic wr_lock;
    logic [7:0] high_wdata;
    logic [7:0] lock_wdata;
    logic prog_q_ff;
    logic prog_edge;
    logic force_now;
    logic nxt_ovr;
    logic [7:0] nxt_rd_data;

    // Fuse writes need programming mode and an unprogrammed lock bit
    assign fuse_unlocked = nv_lock[`LK_FIRST];
    assign fuse_wr_ok = prog_mode_in && fuse_wr_in && fuse_unlocked;
    assign wr_low = fuse_wr_ok && (fuse_sel_t'(fuse_sel_in) == FS_LOW);
    assign wr_high = fuse_wr_ok && (fuse_sel_t'(fuse_sel_in) == FS_HIGH);
    assign wr_ext = fuse_wr_ok && (fuse_sel_t'(fuse_sel_in) == FS_EXT);
    // Lock bits only go toward programmed; erase and power-up reset clear them
    assign wr_lock = prog_mode_in && lock_wr_in;
    assign lock_wdata = nv_lock & wdata_in;

    // Serial path keeps the serial-enable bit as it is
    always_comb begin
        high_wdata = wdata_in;
        if (prog_serial_in) begin
            high_wdata[`HB_SER_PROG] = nv_high[`HB_SER_PROG];
        end
    end

    // Fuse bytes: erase input tied off, chip erase never reaches them
    nv_byte_cell #(
        .WIDTH(8),
        .RST_VAL(`LOW_FUSE_RST)
    ) u_low (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_low),
        .erase_in(1'b0),
        .wdata_in(wdata_in),
        .q_out(nv_low)
    );

    nv_byte_cell #(
        .WIDTH(8),
        .RST_VAL(`HIGH_FUSE_RST)
    ) u_high (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_high),
        .erase_in(1'b0),
        .wdata_in(high_wdata),
        .q_out(nv_high)
    );

    nv_byte_cell #(
        .WIDTH(8),
        .RST_VAL(`EXT_FUSE_RST)
    ) u_ext (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_ext),
        .erase_in(1'b0),
        .wdata_in(wdata_in),
        .q_out(nv_ext)
    );

    nv_byte_cell #(
        .WIDTH(8),
        .RST_VAL(`LOCK_RST)
    ) u_lock (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_lock),
        .erase_in(prog_mode_in && chip_erase_in),
        .wdata_in(lock_wdata),
        .q_out(nv_lock)
    );

    // Programming mode edge; both entry and exit recapture the fuses
    assign prog_edge = prog_mode_in ^ prog_q_ff;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prog_q_ff <= 1'b0;
        end else begin
            prog_q_ff <= prog_mode_in;
        end
    end

    // Latched copies; power-up loads the delivered values, as the cells do
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fuse_low_out <= `LOW_FUSE_RST;
            fuse_high_out <= `HIGH_FUSE_RST;
            fuse_ext_out <= `EXT_FUSE_RST;
        end else if (prog_edge) begin
            fuse_low_out <= nv_low;
            fuse_high_out <= nv_high;
            fuse_ext_out <= nv_ext;
        end
    end

    // Preserve fuse follows the stored bit, not the latched copy
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eeprom_preserve_out <= 1'b0;
        end else begin
            eeprom_preserve_out <= ~nv_high[`HB_EE_KEEP];
        end
    end

    // Clock-out select for port B bit 0, active when fuse reads 0
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            portb0_clock_sel_out <= 1'b0;
        end else begin
            portb0_clock_sel_out <= ~fuse_low_out[`LB_CLK_OUT];
        end
    end

    // Override flag: armed by device reset, released by config write.
    // Reset takes priority so a write during reset cannot release it.
    always_comb begin
        nxt_ovr = override_active_out;
        if (dev_reset_in) begin
            nxt_ovr = ~fuse_ext_out[`EB_PWM_OVR];
        end else if (poc_wr_in) begin
            nxt_ovr = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            override_active_out <= 1'b0;
        end else begin
            override_active_out <= nxt_ovr;
        end
    end

    // Force while reset is held too, not only once the flag is set
    assign force_now = nxt_ovr;

    pwm_force_side #(
        .N(PWM_CHANNELS)
    ) u_side_a (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .force_in(force_now),
        .level_fuse_in(fuse_ext_out[`EB_LVL_A]),
        .port_in(port_a_in),
        .pin_out(pwm_out_side_a_out)
    );

    pwm_force_side #(
        .N(PWM_CHANNELS)
    ) u_side_b (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .force_in(force_now),
        .level_fuse_in(fuse_ext_out[`EB_LVL_B]),
        .port_in(port_b_in),
        .pin_out(pwm_out_side_b_out)
    );

    // Trim register: every reset reloads the calibration byte
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rc_osc_trim_out <= CAL_VALUE;
        end else if (dev_reset_in) begin
            rc_osc_trim_out <= CAL_VALUE;
        end else if (trim_wr_in) begin
            rc_osc_trim_out <= trim_wdata_in;
        end
    end

    // Read mux; no lock or path check, identity stays visible
    always_comb begin
        nxt_rd_data = `UNUSED_READ;
        case (rd_space_t'(rd_space_in))
            SP_IDENT: begin
                case (rd_addr_in)
                    `ID_ADDR0: nxt_rd_data = ID_BYTE0;
                    `ID_ADDR1: nxt_rd_data = ID_BYTE1;
                    `ID_ADDR2: nxt_rd_data = ID_BYTE2;
                    default: nxt_rd_data = `UNUSED_READ;
                endcase
            end
            SP_CALIB: begin
                if (rd_addr_in == `ID_ADDR0) begin
                    nxt_rd_data = CAL_VALUE;
                end
            end
            SP_FUSE: begin
                // Raw stored bits: 0 is programmed
                case (fuse_sel_t'(rd_addr_in))
                    FS_LOW: nxt_rd_data = nv_low;
                    FS_HIGH: nxt_rd_data = nv_high;
                    FS_EXT: nxt_rd_data = nv_ext;
                    FS_LOCK: nxt_rd_data = nv_lock;
                    default: nxt_rd_data = `UNUSED_READ;
                endcase
            end
            default: nxt_rd_data = `UNUSED_READ;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= `UNUSED_READ;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_in;
            if (rd_in) begin
                rd_data_out <= nxt_rd_data;
            end
        end
    end

    // Refused fuse write flagged for one cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_refused_out <= 1'b0;
        end else begin
            wr_refused_out <= prog_mode_in && fuse_wr_in
                && !fuse_unlocked;
        end
    end

    // Checks

    ovr_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        poc_wr_in && !dev_reset_in |=> !override_active_out)
        else $error("override not released by config write");

    ovr_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        override_active_out && !poc_wr_in && !dev_reset_in
        |=> override_active_out)
        else $error("override dropped without config write");

    ovr_arm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        dev_reset_in |=> override_active_out
            == !$past(fuse_ext_out[`EB_PWM_OVR]))
        else $error("override arm does not follow fuse");

    port_pass_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !rst_in && !override_active_out && !dev_reset_in
        |=> pwm_out_side_b_out == $past(port_b_in))
        else $error("port value not passed through");

    side_b_lvl_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        override_active_out && !poc_wr_in && !dev_reset_in
        |=> pwm_out_side_b_out
            == {PWM_CHANNELS{~fuse_ext_out[`EB_LVL_B]}})
        else $error("side b forced level wrong");

    lock_refuse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !nv_lock[`LK_FIRST] |=> $stable(nv_low) && $stable(nv_high)
            && $stable(nv_ext))
        else $error("fuse changed while locked");

    serial_keep_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        prog_serial_in |=> $stable(nv_high[`HB_SER_PROG]))
        else $error("serial path altered serial enable");

    latch_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        prog_mode_in && prog_q_ff ##1 prog_mode_in
        |-> $stable(fuse_high_out) && $stable(fuse_low_out))
        else $error("latched fuses moved inside programming");

    ee_now_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_high |=> ##1 eeprom_preserve_out
            == !$past(high_wdata[`HB_EE_KEEP], 2))
        else $error("preserve fuse not applied at once");

    trim_copy_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        dev_reset_in |=> rc_osc_trim_out == CAL_VALUE)
        else $error("trim not reloaded on reset");

    id_read_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        rd_in && rd_space_in == SP_IDENT && rd_addr_in == `ID_ADDR1
        |=> rd_valid_out && rd_data_out == ID_BYTE1)
        else $error("identification byte read wrong");

endmodule // fuse_config_and_signature

/* File: hdl/fuse_consts.svh */
`ifndef FUSE_CONSTS_SVH
`define FUSE_CONSTS_SVH

// Delivered contents of the fuse and lock bytes (0 = programmed)
`define LOW_FUSE_RST 8'h62
`define HIGH_FUSE_RST 8'hd9
`define EXT_FUSE_RST 8'hff
`define LOCK_RST 8'hff
`define ERASED_BYTE 8'hff
`define UNUSED_READ 8'h00

// Extended byte fields
`define EB_PWM_OVR 5
`define EB_LVL_A 4
`define EB_LVL_B 3

// High byte fields
`define HB_EXT_RST_DIS 7
`define HB_ONEWIRE_DBG 6
`define HB_SER_PROG 5
`define HB_WDOG_ON 4
`define HB_EE_KEEP 3
`define HB_BOOT_HI 2
`define HB_BOOT_LO 1
`define HB_RST_VEC 0

// Low byte fields
`define LB_DIV8 7
`define LB_CLK_OUT 6
`define LB_SUT_HI 5
`define LB_SUT_LO 4
`define LB_CKS_HI 3
`define LB_CKS_LO 0

// Lock byte: first memory lock bit
`define LK_FIRST 0

// Identification space addresses
`define ID_ADDR0 2'h0
`define ID_ADDR1 2'h1
`define ID_ADDR2 2'h2

`endif

/* File: hdl/fuse_pkg.sv */
package fuse_pkg;

    // Address space selected by a read
    typedef enum logic [1:0] {
        SP_IDENT = 2'b00,
        SP_CALIB = 2'b01,
        SP_FUSE = 2'b10,
        SP_NONE = 2'b11
    } rd_space_t;

    // Byte selected by a fuse write or a fuse-space read
    typedef enum logic [1:0] {
        FS_LOW = 2'b00,
        FS_HIGH = 2'b01,
        FS_EXT = 2'b10,
        FS_LOCK = 2'b11
    } fuse_sel_t;

endpackage

/* File: hdl/nv_byte_cell.sv */
`timescale 1ns/1ps
`include "fuse_consts.svh"

// One non-volatile byte; the caller decides what a write stores
module nv_byte_cell #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic erase_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] q_out
);

    initial begin
        if (WIDTH < 1) $error("nv_byte_cell: WIDTH must be positive");
    end

    // Erase wins over write: it returns every bit to unprogrammed
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_out <= RST_VAL;
        end else if (erase_in) begin
            q_out <= '1;
        end else if (wr_in) begin
            q_out <= wdata_in;
        end
    end

    cell_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !wr_in && !erase_in |=> $stable(q_out))
        else $error("cell changed without write or erase");

endmodule // nv_byte_cell

/* File: hdl/pwm_force_side.sv */
`timescale 1ns/1ps

// Drives one side of the power-stage outputs: forced level or port value
module pwm_force_side #(
    parameter int N = 3
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic force_in,
    input wire logic level_fuse_in,
    input wire logic [N-1:0] port_in,
    output logic [N-1:0] pin_out
);

    initial begin
        if (N < 1) $error("pwm_force_side: N must be positive");
    end

    // Programmed level fuse (0) means high; async reset is a safe low
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= '0;
        end else if (force_in) begin
            pin_out <= {N{~level_fuse_in}};
        end else begin
            pin_out <= port_in;
        end
    end

    side_level_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        force_in |=> pin_out == {N{~$past(level_fuse_in)}})
        else $error("forced side level wrong");

endmodule // pwm_force_side

/* File: test/fuse_programmer_model.sv */
`timescale 1ns/1ps

// Programmer on the far side: drives mode, strobes and reads
module fuse_programmer_model (
    input wire logic ref_clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic wr_refused_in,
    output logic prog_mode_out,
    output logic prog_serial_out,
    output logic fuse_wr_out,
    output logic [1:0] fuse_sel_out,
    output logic [7:0] wdata_out,
    output logic lock_wr_out,
    output logic chip_erase_out,
    output logic rd_out,
    output logic [1:0] rd_space_out,
    output logic [1:0] rd_addr_out
);
    initial begin
        prog_mode_out = 1'b0;
        prog_serial_out = 1'b0;
        fuse_wr_out = 1'b0;
        fuse_sel_out = 2'h3;
        wdata_out = 8'h00;
        lock_wr_out = 1'b0;
        chip_erase_out = 1'b0;
        rd_out = 1'b0;
        rd_space_out = 2'h3;
        rd_addr_out = 2'h0;
    end

    // Mode change; the latch reload needs a couple of edges to land
    task automatic set_mode(input logic mode, input logic serial);
        @(posedge ref_clk_in);
        prog_mode_out <= mode;
        prog_serial_out <= serial;
        repeat (3) @(posedge ref_clk_in);
    endtask

    // Kind 0 fuse write, 1 lock write, 2 erase; data inverted on release
    task automatic strobe(input logic [1:0] kind, input logic [1:0] sel,
                          input logic [7:0] data, output logic refused);
        @(posedge ref_clk_in);
        fuse_wr_out <= (kind == 2'h0);
        lock_wr_out <= (kind == 2'h1);
        chip_erase_out <= (kind == 2'h2);
        fuse_sel_out <= sel;
        wdata_out <= data;
        @(posedge ref_clk_in);
        fuse_wr_out <= 1'b0;
        lock_wr_out <= 1'b0;
        chip_erase_out <= 1'b0;
        fuse_sel_out <= 2'h3;
        wdata_out <= ~data;
        @(posedge ref_clk_in);
        refused = wr_refused_in;
    endtask

    // Read with a bounded wait for the valid pulse
    task automatic read(input logic [1:0] space, input logic [1:0] addr,
                        output logic [7:0] data);
        @(posedge ref_clk_in);
        rd_out <= 1'b1;
        rd_space_out <= space;
        rd_addr_out <= addr;
        @(posedge ref_clk_in);
        rd_out <= 1'b0;
        rd_addr_out <= ~addr;
        data = 8'hxx;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_in);
            if (rd_valid_in === 1'b1) begin
                data = rd_data_in;
                break;
            end
        end
    endtask
endmodule // fuse_programmer_model

/* File: test/fuse_config_and_signature_tb.sv */
`timescale 1ns/1ps

module fuse_config_and_signature_tb
    import fuse_pkg::*;
;
    localparam logic [7:0] ID0 = 8'h5a; // Arbitrary identification value
    localparam logic [7:0] ID1 = 8'h3c; // Arbitrary identification value
    localparam logic [7:0] ID2 = 8'ha5; // Arbitrary identification value
    localparam logic [7:0] CAL = 8'h80;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dev_rst = 1'b0;
    logic poc_wr = 1'b0;
    logic [2:0] port_a = 3'h5;
    logic [2:0] port_b = 3'h2;
    logic trim_wr = 1'b0;
    logic [7:0] trim_wd = 8'h00;
    logic pm, ps, fw, lw, ce, rd, rv, refd, ovr, pres, csel;
    logic [1:0] fsel, rsp, radr;
    logic [7:0] wd, rdd, trim, f_low, f_high, f_ext;
    logic [2:0] pwm_a, pwm_b;
    int errors = 0;
    int compares = 0;

    always #2 clk = ~clk;

    fuse_config_and_signature #(.ID_BYTE0(ID0), .ID_BYTE1(ID1),
        .ID_BYTE2(ID2), .CAL_VALUE(CAL), .PWM_CHANNELS(3)) dut (
        .ref_clk_in(clk), .rst_in(rst), .dev_reset_in(dev_rst),
        .prog_mode_in(pm), .prog_serial_in(ps), .fuse_wr_in(fw),
        .fuse_sel_in(fsel), .wdata_in(wd), .lock_wr_in(lw),
        .chip_erase_in(ce), .rd_in(rd), .rd_space_in(rsp),
        .rd_addr_in(radr), .poc_wr_in(poc_wr), .port_a_in(port_a),
        .port_b_in(port_b), .trim_wr_in(trim_wr), .trim_wdata_in(trim_wd),
        .rd_data_out(rdd), .rd_valid_out(rv), .wr_refused_out(refd),
        .pwm_out_side_a_out(pwm_a), .pwm_out_side_b_out(pwm_b),
        .override_active_out(ovr), .rc_osc_trim_out(trim),
        .fuse_low_out(f_low), .fuse_high_out(f_high), .fuse_ext_out(f_ext),
        .eeprom_preserve_out(pres), .portb0_clock_sel_out(csel));

    fuse_programmer_model prog (
        .ref_clk_in(clk), .rd_data_in(rdd), .rd_valid_in(rv),
        .wr_refused_in(refd), .prog_mode_out(pm), .prog_serial_out(ps),
        .fuse_wr_out(fw), .fuse_sel_out(fsel), .wdata_out(wd),
        .lock_wr_out(lw), .chip_erase_out(ce), .rd_out(rd),
        .rd_space_out(rsp), .rd_addr_out(radr));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One-cycle device reset; outputs settle one edge later
    task automatic pulse_dev_reset();
        @(posedge clk);
        dev_rst <= 1'b1;
        @(posedge clk);
        dev_rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_delivered();
        logic [7:0] d;
        check("fuse_low", f_low, 8'h62);
        check("fuse_high", f_high, 8'hd9);
        check("fuse_ext", f_ext, 8'hff);
        check("clk_sel", {7'h0, csel}, 8'h00);
        check("preserve", {7'h0, pres}, 8'h00);
        prog.read(SP_FUSE, 2'h1, d);
        check("stored_high", d, 8'hd9);
        $display("delivered test done");
    endtask

    task automatic t_ident();
        logic [7:0] d;
        logic [7:0] exp [4] = '{ID0, ID1, ID2, 8'h00};
        for (int i = 0; i < 4; i++) begin
            prog.read(SP_IDENT, 2'(i), d);
            check("ident", d, exp[i]);
        end
        prog.read(SP_CALIB, 2'h0, d);
        check("calib", d, CAL);
        $display("ident test done");
    endtask

    // Preserve acts at once, other fuses wait for mode exit
    task automatic t_latch();
        logic r;
        prog.set_mode(1'b1, 1'b0);
        prog.strobe(2'h0, FS_HIGH, 8'hd1, r);
        @(posedge clk);
        check("preserve", {7'h0, pres}, 8'h01);
        check("fuse_high", f_high, 8'hd9);
        prog.strobe(2'h0, FS_LOW, 8'h22, r);
        check("clk_sel", {7'h0, csel}, 8'h00);
        prog.set_mode(1'b0, 1'b0);
        check("fuse_high", f_high, 8'hd1);
        check("clk_sel", {7'h0, csel}, 8'h01);
        $display("latch test done");
    endtask

    // Serial path: identity readable, serial-enable bit left alone
    task automatic t_serial();
        logic r;
        logic [7:0] d;
        prog.set_mode(1'b1, 1'b1);
        prog.read(SP_IDENT, 2'h0, d);
        check("ident_serial", d, ID0);
        prog.strobe(2'h0, FS_HIGH, 8'hf0, r);
        prog.set_mode(1'b0, 1'b0);
        check("fuse_high", f_high, 8'hd0);
        $display("serial test done");
    endtask

    // Every pair of level fuses, then release by config write
    task automatic t_override();
        logic r;
        logic a;
        logic b;
        pulse_dev_reset();
        check("override", {7'h0, ovr}, 8'h00);
        check("side_a", {5'h0, pwm_a}, {5'h0, port_a});
        for (int i = 0; i < 4; i++) begin
            a = i[1];
            b = i[0];
            prog.set_mode(1'b1, 1'b0);
            prog.strobe(2'h0, FS_EXT, {3'b110, a, b, 3'b111}, r);
            prog.set_mode(1'b0, 1'b0);
            pulse_dev_reset();
            check("override", {7'h0, ovr}, 8'h01);
            check("side_a", {5'h0, pwm_a}, a ? 8'h00 : 8'h07);
            check("side_b", {5'h0, pwm_b}, b ? 8'h00 : 8'h07);
            port_a <= ~port_a;
            repeat (3) @(posedge clk);
            check("side_a", {5'h0, pwm_a}, a ? 8'h00 : 8'h07);
            poc_wr <= 1'b1;
            @(posedge clk);
            poc_wr <= 1'b0;
            repeat (2) @(posedge clk);
            check("side_a", {5'h0, pwm_a}, {5'h0, port_a});
            check("side_b", {5'h0, pwm_b}, {5'h0, port_b});
        end
        $display("override test done");
    endtask

    task automatic t_trim();
        @(posedge clk);
        trim_wr <= 1'b1;
        trim_wd <= 8'h3c;
        @(posedge clk);
        trim_wr <= 1'b0;
        @(posedge clk);
        check("trim", trim, 8'h3c);
        pulse_dev_reset();
        check("trim", trim, CAL);
        $display("trim test done");
    endtask

    // Erase spares fuses; a locked part refuses fuse writes
    task automatic t_lock();
        logic r;
        logic [7:0] d;
        prog.set_mode(1'b1, 1'b0);
        prog.strobe(2'h2, FS_LOW, 8'h00, r);
        prog.read(SP_FUSE, 2'h0, d);
        check("stored_low", d, 8'h22);
        prog.strobe(2'h1, FS_LOW, 8'hfe, r);
        prog.strobe(2'h0, FS_LOW, 8'h62, r);
        check("refused", {7'h0, r}, 8'h01);
        prog.read(SP_FUSE, 2'h0, d);
        check("stored_low", d, 8'h22);
        prog.read(SP_IDENT, 2'h2, d);
        check("ident", d, ID2);
        prog.set_mode(1'b0, 1'b0);
        $display("lock test done");
    endtask

    // A second power-up brings back the delivered contents
    task automatic t_power();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("fuse_low", f_low, 8'h62);
        check("trim", trim, CAL);
        $display("power test done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_delivered();
        t_ident();
        t_latch();
        t_serial();
        t_override();
        t_trim();
        t_lock();
        t_power();
        report_and_stop();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
endmodule // fuse_config_and_signature_tb
